// ### inc/buck_ctl_pkg.sv
// constants shared by the regulator control block and its helpers
`default_nettype none
package buck_ctl_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 250;                  // mclk rate
  localparam int ENABLE_DELAY_US = 400;          // enable delay, plain default
  localparam int STARTUP_PERIOD_US = 1000;       // startup period, plain default
  localparam int GOOD_START_US = 200;            // wait after reaching nominal
  localparam int DEGLITCH_US = 16;               // power-good deglitch, plain default
  localparam int ENABLE_DELAY_CYC = ENABLE_DELAY_US * CLK_MHZ;
  localparam int STARTUP_PERIOD_CYC = STARTUP_PERIOD_US * CLK_MHZ;
  localparam int GOOD_START_CYC = GOOD_START_US * CLK_MHZ;
  localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
  localparam int CNT_W = 20;                     // wide enough for every long wait

  // ramp step times per ramp speed code, least times round up
  localparam int STEP_NS_00 = 250;               // 20 mV/us
  localparam int STEP_NS_01 = 500;               // 10 mV/us
  localparam int STEP_NS_10 = 1000;              // 5 mV/us
  localparam int STEP_NS_11 = 5000;              // 1 mV/us
  localparam logic [11:0] STEP_CYC_00 = 12'((STEP_NS_00 * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] STEP_CYC_01 = 12'((STEP_NS_01 * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] STEP_CYC_10 = 12'((STEP_NS_10 * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] STEP_CYC_11 = 12'((STEP_NS_11 * CLK_MHZ + 999) / 1000);

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_SETPOINT1 = 8'h01;
  localparam logic [7:0] ADDR_SETPOINT2 = 8'h02;
  localparam logic [7:0] ADDR_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] SETPOINT_RESET = 8'h64;
  localparam logic [7:0] CONTROL_RESET = 8'h6F;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // control fields
  localparam int CTL_SOFT_RESET = 7;
  localparam int CTL_PWM_ON_CHANGE = 6;
  localparam int CTL_SW_ENABLE = 5;
  localparam int CTL_FORCED_PWM = 4;
  localparam int CTL_DISCHARGE = 3;
  localparam int CTL_HICCUP = 2;
  localparam int CTL_RAMP_LO = 0;                // two bits, 1:0

  // status fields
  localparam int STS_THERMAL_WARN = 4;
  localparam int STS_HICCUP = 3;

  // bus codes
  localparam logic [4:0] MASTER_CODE_TOP = 5'b00001;
  localparam logic [3:0] BIT_ACK = 4'h8;          // ninth bit slot

  // ************************************************************
  // state encodings
  // ************************************************************
  typedef enum logic [4:0] {
    LNK_ADDR = 5'b00001,
    LNK_REG = 5'b00010,
    LNK_DATA = 5'b00100,
    LNK_READ = 5'b01000,
    LNK_IGNORE = 5'b10000
  } link_state_t;

  typedef enum logic [3:0] {
    PH_OFF = 4'b0001,
    PH_DELAY = 4'b0010,
    PH_STARTUP = 4'b0100,
    PH_RUN = 4'b1000
  } phase_t;

endpackage : buck_ctl_pkg
`default_nettype wire

// ### hdl/pin_sync3.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module pin_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] filt
);

  // ************************************************************
  // stages
  // ************************************************************
  logic [W-1:0] s1_reg; // metastable stage, read only by s2
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // plain three-flop chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts only once stage two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule : pin_sync3
`default_nettype wire

// ### hdl/dvs_i2c_slave_power_good.sv
// regulator control: i2c slave, registers, setpoint ramp and power-good
`default_nettype none
// Operation
// - after startup, select pin picks setpoint register
// - force pwm and ramp during setpoint change
// - power-good low only inside output window
// - power-good variant disables second setpoint register
// - deglitch changes; 200 us start wait
// - slave at standard, fast, plus, high speed
// - registers kept unless an explicit reset
// - start is sda fall with scl high
// - stop is sda rise, releases link
// - ack only matching seven-bit address
// - each byte followed by receiver acknowledge
// - unmapped register reads return zero
// - master code not acked, selects high speed
// - stop returns interface to slower mode
// - write is address, register, data, each acked
// - commit on falling edge ending the ack
// - enable fall or soft reset restores defaults
// - soft reset restarts; writable after enable delay
// - ramp code 00..11 is 20,10,5,1 mV/us
// - whole register byte selects register
// - no bus response while enable pin low
module dvs_i2c_slave_power_good
  import buck_ctl_pkg::*;
#(
  parameter int ENABLE_DELAY = buck_ctl_pkg::ENABLE_DELAY_CYC,
  parameter int STARTUP_PERIOD = buck_ctl_pkg::STARTUP_PERIOD_CYC,
  parameter int GOOD_START = buck_ctl_pkg::GOOD_START_CYC
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // i2c link, scl also clocks the link logic
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // device pins and straps
  input wire logic enable_pin,
  input wire logic voltage_select_pin,
  input wire logic power_good_variant,
  input wire logic [6:0] slave_addr,
  // analog status levels
  input wire logic vout_in_window,
  input wire logic thermal_shutdown,
  input wire logic thermal_warning,
  input wire logic hiccup_seen,
  // regulator controls
  output logic [7:0] setpoint_code,
  output logic forced_pwm,
  output logic dynamic_voltage_scaling,
  output logic switching_enable,
  output logic discharge_enable,
  output logic hiccup_enable,
  output logic high_speed_mode,
  // power-good pin, driven high or released
  output logic power_good_pin_o,
  output logic power_good_pin_oe
);
  import buck_ctl_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [7:0] pins_f; // filtered pin levels
  logic scl_f, sda_f, en_f, vsel_f, win_f, tsd_f, warn_f, hic_f;
  logic [2:0] tgl_f; // filtered link toggles
  logic ptr_tgl_reg, wr_tgl_reg, mc_tgl_reg; // link-side event toggles

  pin_sync3 #(.W(8)) u_pins (
    .clk(mclk),
    .rst_n(nrst),
    .raw({scl_clk, sda_i, enable_pin, voltage_select_pin, vout_in_window, thermal_shutdown,
          thermal_warning, hiccup_seen}),
    .filt(pins_f)
  );
  assign {scl_f, sda_f, en_f, vsel_f, win_f, tsd_f, warn_f, hic_f} = pins_f;

  pin_sync3 #(.W(3)) u_tgls (
    .clk(mclk),
    .rst_n(nrst),
    .raw({ptr_tgl_reg, wr_tgl_reg, mc_tgl_reg}),
    .filt(tgl_f)
  );

  // ************************************************************
  // start and stop detection on mclk
  // ************************************************************
  logic scl_d_reg, sda_d_reg, en_d_reg; // previous filtered levels
  logic [2:0] tgl_d_reg; // previous toggle levels
  logic start_ev, stop_ev, en_fall, ptr_ev, wr_ev, mc_ev;
  logic frame_rst_reg; // holds link logic at its frame start
  logic link_rst_n;

  // edge memory for filtered inputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      en_d_reg <= 1'b0;
      tgl_d_reg <= 3'h0;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      en_d_reg <= en_f;
      tgl_d_reg <= tgl_f;
    end
  end

  assign start_ev = scl_f && scl_d_reg && sda_d_reg && !sda_f;
  assign stop_ev = scl_f && scl_d_reg && !sda_d_reg && sda_f;
  assign en_fall = en_d_reg && !en_f;
  assign {ptr_ev, wr_ev, mc_ev} = tgl_f ^ tgl_d_reg;

  // start or stop resets the link logic until scl goes low again;
  // safe because scl low lasts far longer than the sync latency
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_rst_reg <= 1'b1;
    end else if (start_ev || stop_ev) begin
      frame_rst_reg <= 1'b1;
    end else if (!scl_f) begin
      frame_rst_reg <= 1'b0;
    end
  end

  assign link_rst_n = nrst && !frame_rst_reg;

  // high speed flag lives here so repeated starts keep it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      high_speed_mode <= 1'b0;
    end else if (stop_ev) begin
      high_speed_mode <= 1'b0;
    end else if (mc_ev) begin
      high_speed_mode <= 1'b1;
    end
  end

  // ************************************************************
  // link logic on scl
  // ************************************************************
  link_state_t lnk_reg; // byte role within the transfer
  logic [3:0] bit_cnt_reg; // bit slot, 8 is the ack slot
  logic [7:0] rx_reg; // received byte
  logic [7:0] tx_reg; // byte being sent
  logic [7:0] ptr_reg; // register pointer
  logic [7:0] wdata_reg; // data waiting for commit
  logic wr_pend_reg; // data byte acked, commit on next fall
  logic nack_reg; // master refused a read byte
  logic open_s1_reg, open_s2_reg; // bus-open level on scl
  logic bus_open_reg; // mclk side: enabled and past the delay
  logic [6:0] addr_reg; // strap caught after enable
  logic [7:0] read_word_reg; // mclk side read data, steady before use

  // sample data and count bits on the rising edge
  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      nack_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_ACK) begin
      bit_cnt_reg <= 4'h0;
      nack_reg <= sda_i;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      rx_reg <= {rx_reg[6:0], sda_i}; // sender keeps sda steady here
    end
  end

  // bus-open level into the link domain
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      open_s1_reg <= 1'b0;
      open_s2_reg <= 1'b0;
    end else begin
      open_s1_reg <= bus_open_reg;
      open_s2_reg <= open_s1_reg;
    end
  end

  // byte decisions and sda drive on the falling edge
  always_ff @(negedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lnk_reg <= LNK_ADDR; // master stop after power-up starts us clean
      sda_oe <= 1'b0;
      tx_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
    end else if (bit_cnt_reg == BIT_ACK) begin
      sda_oe <= 1'b0;
      unique case (lnk_reg)
        LNK_ADDR: begin
          if (rx_reg[7:3] == MASTER_CODE_TOP) begin
            lnk_reg <= LNK_IGNORE; // no ack
          end else if (rx_reg[7:1] == addr_reg && open_s2_reg) begin
            sda_oe <= 1'b1;
            lnk_reg <= rx_reg[0] ? LNK_READ : LNK_REG;
            tx_reg <= read_word_reg;
          end else begin
            lnk_reg <= LNK_IGNORE;
          end
        end
        LNK_REG: begin
          sda_oe <= 1'b1;
          lnk_reg <= LNK_DATA;
        end
        LNK_DATA: begin
          sda_oe <= 1'b1;
          wr_pend_reg <= 1'b1;
        end
        LNK_READ: begin
          tx_reg <= read_word_reg; // master acks, next byte
        end
        LNK_IGNORE: begin
          lnk_reg <= LNK_IGNORE;
        end
      endcase
    end else if (bit_cnt_reg == 4'h0 && lnk_reg == LNK_READ && nack_reg) begin
      sda_oe <= 1'b0; // not-acknowledge ends the read
      lnk_reg <= LNK_IGNORE;
    end else begin
      wr_pend_reg <= 1'b0;
      sda_oe <= (lnk_reg == LNK_READ) && !tx_reg[3'h7 - bit_cnt_reg[2:0]];
    end
  end

  // pointer and write data capture, one toggle per event
  always_ff @(negedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      ptr_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      mc_tgl_reg <= 1'b0;
      sda_o <= 1'b0;
    end else if (bit_cnt_reg == BIT_ACK && lnk_reg == LNK_REG) begin
      ptr_reg <= rx_reg;
      ptr_tgl_reg <= !ptr_tgl_reg;
    end else if (bit_cnt_reg == BIT_ACK && lnk_reg == LNK_DATA) begin
      wdata_reg <= rx_reg;
    end else if (bit_cnt_reg == BIT_ACK && lnk_reg == LNK_ADDR
                 && rx_reg[7:3] == MASTER_CODE_TOP) begin
      mc_tgl_reg <= !mc_tgl_reg;
    end else if (wr_pend_reg && bit_cnt_reg == 4'h0) begin
      wr_tgl_reg <= !wr_tgl_reg; // falling edge ending the ack
    end
  end

  // ************************************************************
  // sequencer: enable delay, startup, run
  // ************************************************************
  phase_t phase_reg; // regulator start-up phase
  logic [CNT_W-1:0] phase_cnt_reg; // time spent in the phase
  logic soft_reset; // control write with reset bit
  logic sw_restart; // software enable rising
  logic [7:0] ctl_reg; // control register
  logic [7:0] set1_reg; // first_setpoint_code
  logic [7:0] set2_reg; // second_setpoint_code
  logic variant_reg; // power-good variant strap
  logic writable;

  assign writable = (phase_reg == PH_STARTUP) || (phase_reg == PH_RUN);
  assign soft_reset = wr_ev && writable && ptr_reg == ADDR_CONTROL
                      && wdata_reg[CTL_SOFT_RESET];
  assign sw_restart = wr_ev && writable && ptr_reg == ADDR_CONTROL
                      && wdata_reg[CTL_SW_ENABLE] && !ctl_reg[CTL_SW_ENABLE];

  // phase walk; soft reset restarts with the full delay
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PH_OFF;
      phase_cnt_reg <= '0;
    end else if (!en_f) begin
      phase_reg <= PH_OFF;
      phase_cnt_reg <= '0;
    end else if (soft_reset || phase_reg == PH_OFF) begin
      phase_reg <= PH_DELAY;
      phase_cnt_reg <= '0;
    end else if (sw_restart) begin
      phase_reg <= PH_STARTUP; // new start without the delay
      phase_cnt_reg <= '0;
    end else begin
      unique case (phase_reg)
        PH_DELAY: begin
          phase_cnt_reg <= phase_cnt_reg + 1'b1;
          if (phase_cnt_reg == CNT_W'(ENABLE_DELAY - 1)) begin
            phase_reg <= PH_STARTUP;
            phase_cnt_reg <= '0;
          end
        end
        PH_STARTUP: begin
          phase_cnt_reg <= phase_cnt_reg + 1'b1;
          if (phase_cnt_reg == CNT_W'(STARTUP_PERIOD - 1)) begin
            phase_reg <= PH_RUN;
          end
        end
        PH_RUN: phase_reg <= PH_RUN;
        PH_OFF: phase_reg <= PH_DELAY;
      endcase
    end
  end

  // straps are caught while the enable delay runs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= 7'h00;
      variant_reg <= 1'b0;
      bus_open_reg <= 1'b0;
    end else begin
      if (phase_reg == PH_DELAY) begin
        addr_reg <= slave_addr;
        variant_reg <= power_good_variant;
      end
      bus_open_reg <= en_f && writable;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  // contents survive everything but the three explicit resets
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      set1_reg <= SETPOINT_RESET;
      set2_reg <= SETPOINT_RESET;
      ctl_reg <= CONTROL_RESET;
    end else if (!en_f || en_fall || soft_reset) begin
      set1_reg <= SETPOINT_RESET;
      set2_reg <= SETPOINT_RESET;
      ctl_reg <= CONTROL_RESET;
    end else if (wr_ev && writable) begin
      unique case (ptr_reg)
        ADDR_SETPOINT1: set1_reg <= wdata_reg;
        ADDR_SETPOINT2: begin
          if (!variant_reg) begin
            set2_reg <= wdata_reg;
          end
        end
        ADDR_CONTROL: ctl_reg <= wdata_reg;
        default: ctl_reg <= ctl_reg; // unmapped write dropped
      endcase
    end
  end

  // read data for the latest pointer, steady long before the read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      read_word_reg <= READ_UNMAPPED;
    end else if (ptr_ev) begin
      unique case (ptr_reg)
        ADDR_SETPOINT1: read_word_reg <= set1_reg;
        ADDR_SETPOINT2: read_word_reg <= variant_reg ? READ_UNMAPPED : set2_reg;
        ADDR_CONTROL: read_word_reg <= ctl_reg;
        ADDR_STATUS: begin
          read_word_reg <= READ_UNMAPPED;
          read_word_reg[STS_THERMAL_WARN] <= warn_f;
          read_word_reg[STS_HICCUP] <= hic_f;
        end
        default: read_word_reg <= READ_UNMAPPED;
      endcase
    end
  end

  // ************************************************************
  // setpoint selection and ramp
  // ************************************************************
  logic [7:0] target; // selected setpoint
  logic [11:0] step_cyc; // cycles per 5 mV step
  logic [11:0] step_cnt_reg;

  assign target = (phase_reg == PH_RUN && vsel_f && !variant_reg) ? set2_reg : set1_reg;

  // ramp speed decode
  always_comb begin
    unique case (ctl_reg[CTL_RAMP_LO +: 2])
      2'b00: step_cyc = STEP_CYC_00;
      2'b01: step_cyc = STEP_CYC_01;
      2'b10: step_cyc = STEP_CYC_10;
      2'b11: step_cyc = STEP_CYC_11;
    endcase
  end

  // one code per step time toward the target
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      setpoint_code <= SETPOINT_RESET;
      step_cnt_reg <= 12'h000;
      dynamic_voltage_scaling <= 1'b0;
    end else if (phase_reg == PH_OFF || phase_reg == PH_DELAY) begin
      setpoint_code <= target;
      step_cnt_reg <= 12'h000;
      dynamic_voltage_scaling <= 1'b0;
    end else if (setpoint_code == target) begin
      step_cnt_reg <= 12'h000;
      dynamic_voltage_scaling <= 1'b0;
    end else begin
      dynamic_voltage_scaling <= 1'b1;
      step_cnt_reg <= step_cnt_reg + 12'h001;
      if (step_cnt_reg >= step_cyc - 12'h001) begin
        step_cnt_reg <= 12'h000;
        setpoint_code <= (setpoint_code < target) ? setpoint_code + 8'h01
                                                  : setpoint_code - 8'h01;
      end
    end
  end

  // mode outputs from control bits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      forced_pwm <= 1'b0;
      switching_enable <= 1'b0;
      discharge_enable <= 1'b1;
      hiccup_enable <= 1'b1;
    end else begin
      forced_pwm <= ctl_reg[CTL_FORCED_PWM]
                    || (ctl_reg[CTL_PWM_ON_CHANGE] && setpoint_code != target);
      switching_enable <= writable && ctl_reg[CTL_SW_ENABLE] && !tsd_f;
      discharge_enable <= ctl_reg[CTL_DISCHARGE];
      hiccup_enable <= ctl_reg[CTL_HICCUP];
    end
  end

  // ************************************************************
  // power good
  // ************************************************************
  logic good_reg; // output judged inside the window
  logic good_started_reg; // first good reached since start
  logic [CNT_W-1:0] good_cnt_reg;

  // start wait once, then deglitch each change
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      good_reg <= 1'b0;
      good_started_reg <= 1'b0;
      good_cnt_reg <= '0;
    end else if (phase_reg == PH_OFF || phase_reg == PH_DELAY || tsd_f) begin
      good_reg <= 1'b0;
      good_started_reg <= 1'b0;
      good_cnt_reg <= '0;
    end else if (!good_started_reg) begin
      good_cnt_reg <= win_f ? good_cnt_reg + 1'b1 : '0;
      if (win_f && good_cnt_reg == CNT_W'(GOOD_START - 1)) begin
        good_reg <= 1'b1;
        good_started_reg <= 1'b1;
        good_cnt_reg <= '0;
      end
    end else if (win_f != good_reg) begin
      good_cnt_reg <= good_cnt_reg + 1'b1;
      if (good_cnt_reg == CNT_W'(DEGLITCH_CYC - 1)) begin
        good_reg <= win_f;
        good_cnt_reg <= '0;
      end
    end else begin
      good_cnt_reg <= '0;
    end
  end

  // pin driven high when not good, released to the pull-down when good
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_good_pin_o <= 1'b1;
      power_good_pin_oe <= 1'b0;
    end else begin
      power_good_pin_o <= 1'b1;
      power_good_pin_oe <= variant_reg && !good_reg;
    end
  end

endmodule : dvs_i2c_slave_power_good
`default_nettype wire

// ### verif/dvs_props_properties.sv
// port checker for the regulator control block
`default_nettype none
module dvs_props (
  // clocks and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_clk,
  // watched pins
  input wire logic enable_pin,
  input wire logic sda_oe,
  input wire logic high_speed_mode,
  input wire logic power_good_pin_o,
  input wire logic [7:0] setpoint_code
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // one code per step, then a quiet gap
  sequence s_step;
    8'(setpoint_code - $past(setpoint_code)) inside {8'h01, 8'hFF};
  endsequence
  sequence s_quiet;
    $stable(setpoint_code)[*8];
  endsequence
  // enable low may snap the setpoint home, so only watch while enabled
  property p_ramp; $changed(setpoint_code) && enable_pin |-> s_step ##1 s_quiet; endproperty
  a_ramp: assert property (p_ramp) else $error("setpoint jump");
  property p_oe_rise; $rose(sda_oe) |-> !scl_clk; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("sda pulled with scl high");
  property p_oe_fall; $fell(sda_oe) |-> !scl_clk; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("sda freed with scl high");
  property p_oe_hold; scl_clk && $past(scl_clk) |-> $stable(sda_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda moved in high phase");
  property p_no_resp; !enable_pin [*8] |-> !$rose(sda_oe); endproperty
  a_no_resp: assert property (p_no_resp) else $error("answer while disabled");
  property p_hs_nack; $rose(high_speed_mode) |-> !sda_oe; endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("master code acked");
  property p_hs_stop; $fell(high_speed_mode) |-> scl_clk; endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("hs left without stop");
  property p_pg_o; power_good_pin_o; endproperty
  a_pg_o: assert property (p_pg_o) else $error("power-good drives low");
endmodule : dvs_props
bind dvs_i2c_slave_power_good dvs_props u_props (.mclk(mclk), .nrst(nrst),
  .scl_clk(scl_clk), .enable_pin(enable_pin), .sda_oe(sda_oe),
  .high_speed_mode(high_speed_mode), .power_good_pin_o(power_good_pin_o),
  .setpoint_code(setpoint_code));
`default_nettype wire

// ### verif/i2c_master_model.sv
// bus master model driving scl and sda for the bench
`default_nettype none
module i2c_master_model (
  // wire level seen on the bus
  input wire logic sda,
  // driven lines, a released sda reads high
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: clock stands still high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start; odd delay keeps scl off the mclk grid
  task automatic start();
    sda_m = 1'b1;
    #17.3 scl = 1'b1;
    #32 sda_m = 1'b0;
    #32 scl = 1'b0;
    #16;
  endtask : start
  // stop: sda rises with scl high, then the bus rests
  task automatic stop();
    sda_m = 1'b0;
    #16 scl = 1'b1;
    #32 sda_m = 1'b1;
    #48;
  endtask : stop
  // eight bits msb first then the ninth, sda moves only in low phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_m = (i < 0) ? 1'b1 : tx[i];
      #16 scl = 1'b1;
      #31 if (i >= 0) rx[i] = sda; else ack = !sda;
      #1 scl = 1'b0;
      #16;
    end
  endtask : xfer
  // write: address, register, data, all acked
  task automatic wr(input logic [6:0] dev, input logic [7:0] r, v, output logic ok);
    logic [7:0] x;
    logic a0, a1, a2;
    start();
    xfer({dev, 1'b0}, x, a0);
    xfer(r, x, a1);
    xfer(v, x, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  // read: pointer write, repeated start, one byte, nack, stop
  task automatic rd(input logic [6:0] dev, input logic [7:0] r, output logic [7:0] v,
                    output logic ok);
    logic [7:0] x;
    logic a0, a1, a2, nk;
    start();
    xfer({dev, 1'b0}, x, a0);
    xfer(r, x, a1);
    start();
    xfer({dev, 1'b1}, x, a2);
    xfer(8'hFF, v, nk);
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : i2c_master_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the regulator control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import buck_ctl_pkg::*;
  localparam logic [6:0] DEV = 7'h46; // strap address, arbitrary
  logic mclk = 1'b0, nrst = 1'b0, en = 1'b0, vsel = 1'b0, tw = 1'b0, ok, win = 1'b1, hc = 1'b0;
  logic [7:0] d;
  wire logic scl, sda_m, sda, sda_o, sda_oe, hs, fp, dv;
  wire logic [7:0] sp;
  int fails = 0, num_checks = 0, cyc = 0;
  // pull-up wire: low while either side pulls
  assign sda = sda_m & ~(sda_oe & ~sda_o);
  i2c_master_model mst (.sda(sda), .scl(scl), .sda_m(sda_m));
  dvs_i2c_slave_power_good #(.ENABLE_DELAY(50), .STARTUP_PERIOD(100), .GOOD_START(20)) uut (
    .mclk(mclk), .nrst(nrst), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .enable_pin(en), .voltage_select_pin(vsel), .power_good_variant(1'b0),
    .slave_addr(DEV), .vout_in_window(win), .thermal_shutdown(1'b0),
    .thermal_warning(tw), .hiccup_seen(hc), .setpoint_code(sp), .forced_pwm(fp),
    .dynamic_voltage_scaling(dv), .switching_enable(), .discharge_enable(),
    .hiccup_enable(), .high_speed_mode(hs), .power_good_pin_o(), .power_good_pin_oe());
  initial begin
    forever #2 mclk = ~mclk;
  end
  // hang guard, well above the run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic ack(input logic e);
    chk({7'h0, ok}, {7'h0, e});
  endtask : ack
  task automatic rchk(input logic [7:0] r, exp);
    mst.rd(DEV, r, d, ok);
    ack(1'b1);
    chk(d, exp);
  endtask : rchk
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
  endtask : pause
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    pause(4);
    nrst <= 1'b1;
    mst.stop();
    mst.rd(DEV, ADDR_CONTROL, d, ok);
    ack(1'b0);
    @(posedge mclk);
    en <= 1'b1;
    tw <= 1'b1;
    hc <= 1'b1;
    pause(200);
    rchk(ADDR_SETPOINT1, SETPOINT_RESET);
    rchk(ADDR_SETPOINT2, SETPOINT_RESET);
    rchk(ADDR_CONTROL, CONTROL_RESET);
    rchk(ADDR_STATUS, 8'h18);
    rchk(8'h04, READ_UNMAPPED);
    rchk(8'h0D, READ_UNMAPPED);
    mst.rd(DEV ^ 7'h01, ADDR_CONTROL, d, ok);
    ack(1'b0);
    $display("done: defaults");
    mst.wr(DEV, ADDR_CONTROL, 8'h6C, ok);
    mst.wr(DEV, ADDR_SETPOINT1, 8'h67, ok);
    ack(1'b1);
    pause(1);
    chk({7'h0, fp}, 8'h01);
    chk({7'h0, dv}, 8'h01);
    pause(300);
    chk(sp, 8'h67);
    chk({7'h0, fp}, 8'h00);
    mst.wr(DEV, ADDR_SETPOINT2, 8'h62, ok);
    @(posedge mclk);
    vsel <= 1'b1;
    pause(400);
    chk(sp, 8'h62);
    mst.wr(DEV, ADDR_SETPOINT2, SETPOINT_RESET, ok);
    $display("done: ramp");
    mst.start();
    mst.xfer(8'h09, d, ok);
    ack(1'b0);
    pause(8);
    chk({7'h0, hs}, 8'h01);
    rchk(ADDR_CONTROL, 8'h6C);
    pause(8);
    chk({7'h0, hs}, 8'h00);
    $display("done: high speed");
    mst.wr(DEV, ADDR_CONTROL, 8'hEC, ok);
    pause(200);
    rchk(ADDR_SETPOINT1, SETPOINT_RESET);
    mst.wr(DEV, ADDR_SETPOINT1, 8'h70, ok);
    @(posedge mclk);
    en <= 1'b0;
    mst.rd(DEV, ADDR_SETPOINT1, d, ok);
    ack(1'b0);
    @(posedge mclk);
    en <= 1'b1;
    pause(200);
    rchk(ADDR_SETPOINT1, SETPOINT_RESET);
    $display("done: resets");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
